// *** core/uts_pkg.sv ***
/*
 * uts_pkg: register map, field layout, token codes and carrier types for
 * the usb transfer status and token register slice.
 * assumes a 32-bit axi4-lite register bus and a usb engine on the same clock.
 */
`default_nettype none
package uts_pkg;
   // register byte offsets, one aligned word each
   localparam int                ADDR_W      = 5;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h00; // transfer_status_window
   localparam logic [ADDR_W-1:0] OFS_FRAME   = 5'h04; // frame_count_upper_register
   localparam logic [ADDR_W-1:0] OFS_TOKEN   = 5'h08; // host_token_register
   localparam logic [ADDR_W-1:0] OFS_IFLAG   = 5'h0c; // usb_irq_flags, read only
   localparam logic [ADDR_W-1:0] OFS_ICLEAR  = 5'h10; // write one to clear
   localparam logic [ADDR_W-1:0] OFS_IENABLE = 5'h14; // interrupt enables

   // status entry field positions
   localparam int ST_EP_LSB = 4;
   localparam int ST_DIR    = 3;
   localparam int ST_ODD    = 2;

   // frame number layout
   localparam int FRAME_W  = 11;
   localparam int FRMH_LSB = 8;
   localparam int FRMH_W   = 3;

   // token register fields and codes
   localparam int         TOK_KIND_LSB = 4;
   localparam logic [3:0] TOK_SETUP    = 4'hd;
   localparam logic [3:0] TOK_IN       = 4'h9;
   localparam logic [3:0] TOK_OUT      = 4'h1;

   // interrupt flag bit positions
   localparam int IRQ_W   = 3;
   localparam int IRQ_TRN = 0;
   localparam int IRQ_SOF = 1;
   localparam int IRQ_OVF = 2;

   // fifo depth and axi responses
   localparam int         STAT_DEPTH  = 4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // one completed transaction as reported by the usb engine
   typedef struct packed {
      logic [3:0] ep;
      logic       dir;
      logic       odd;
   } uts_xact_t;

   // start-of-frame token with its frame number
   typedef struct packed {
      logic               seen;
      logic [FRAME_W-1:0] frame;
   } uts_sof_t;

   typedef enum logic [2:0] {
      SEL_STATUS, SEL_FRAME, SEL_TOKEN, SEL_IFLAG, SEL_ICLEAR, SEL_IENABLE, SEL_NONE
   } uts_sel_t;
endpackage : uts_pkg
`default_nettype wire

// *** core/uts_core.sv ***
/*
 * uts_core: axi4-lite register slice holding the transaction status fifo,
 * the upper frame number bits, the host token register and the interrupt.
 * assumes the usb engine runs on clk_sys and gives one-cycle strobes.
 */
// Added by the designer: the address map and the AXI4-Lite slave port.
// Contract
// - status entry bits 7-4 hold the endpoint of the last transfer
// - status bit 3 is one for transmit, zero for receive
// - status bit 2 is one for odd bank, zero for even bank
// - status entries queue in a four-deep fifo; register shows the head
// - clearing the transaction-done flag pops the head entry
// - frame-high register shows frame number bits 10-8 in bits 2-0
// - each start-of-frame token loads the frame-high bits
// - token kinds: 1101 setup, 1001 in, 0001 out
// - unimplemented bits read as zero
`default_nettype none
module uts_core
   import uts_pkg::*;
#(
   parameter int DEPTH = STAT_DEPTH
)(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   // axi4-lite write
   input  wire logic [31:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output var  logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output var  logic                   s_axi_wready,
   output var  logic [1:0]             s_axi_bresp,
   output var  logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // axi4-lite read
   input  wire logic [31:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output var  logic                   s_axi_arready,
   output var  logic [31:0]            s_axi_rdata,
   output var  logic [1:0]             s_axi_rresp,
   output var  logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // usb engine events
   input  wire logic                   xact_done,
   input  wire uts_pkg::uts_xact_t     xact_info,
   input  wire uts_pkg::uts_sof_t      sof_in,
   // token command and interrupt
   output var  logic [3:0]             token_kind,
   output var  logic [3:0]             token_endpoint,
   output var  logic                   token_go,
   output var  logic                   irq
);
   import uts_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);

   // shift-register fifo keeps the head at slot 0, so no read pointer
   generate
      if (DEPTH < 1 || DEPTH > 15)
      begin : g_bad_depth
         $error("uts_core: DEPTH must be 1 to 15");
      end
   endgenerate

   typedef struct packed {
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
      logic                   aw_hold;
      logic [ADDR_W-1:0]      awaddr;
      logic                   w_hold;
      logic [7:0]             wdata;
      logic                   wbyte;
      uts_xact_t [DEPTH-1:0]  q;
      logic [CW-1:0]          cnt;
      logic [FRMH_W-1:0]      frame_hi;
      logic [3:0]             tok_kind;
      logic [3:0]             tok_ep;
      logic                   tok_go;
      logic                   sof_flag;
      logic                   ovf_flag;
      logic [IRQ_W-1:0]       irq_en;
      logic                   irq;
   } uts_state_t;

   uts_state_t st_reg;
   uts_state_t st_next;

   // address decode shared by read and write paths
   function automatic uts_sel_t uts_decode(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_STATUS:  uts_decode = SEL_STATUS;
         OFS_FRAME:   uts_decode = SEL_FRAME;
         OFS_TOKEN:   uts_decode = SEL_TOKEN;
         OFS_IFLAG:   uts_decode = SEL_IFLAG;
         OFS_ICLEAR:  uts_decode = SEL_ICLEAR;
         OFS_IENABLE: uts_decode = SEL_IENABLE;
         default:     uts_decode = SEL_NONE;
      endcase
   endfunction : uts_decode

   function automatic logic uts_token_legal(input logic [3:0] k);
      uts_token_legal = (k == TOK_SETUP) || (k == TOK_IN) || (k == TOK_OUT);
   endfunction : uts_token_legal

   // next-state logic for the whole block
   always_comb
   begin
      logic              pop;
      logic              push;
      logic              clr_sof;
      logic              clr_ovf;
      logic [CW-1:0]     idx;
      logic [IRQ_W-1:0]  flags;
      pop     = 1'b0;
      push    = xact_done;
      clr_sof = 1'b0;
      clr_ovf = 1'b0;
      idx     = '0;
      flags   = '0;
      st_next = st_reg;
      st_next.tok_go = 1'b0;

      // address and data may arrive in either order
      if (s_axi_awvalid && st_reg.awready)
      begin
         st_next.aw_hold = 1'b1;
         st_next.awaddr  = s_axi_awaddr[ADDR_W-1:0];
      end
      if (s_axi_wvalid && st_reg.wready)
      begin
         st_next.w_hold = 1'b1;
         st_next.wdata  = s_axi_wdata[7:0];
         st_next.wbyte  = s_axi_wstrb[0]; // all live bits sit in byte 0
      end
      if (s_axi_bready && st_reg.bvalid)
         st_next.bvalid = 1'b0;

      // perform the write once both halves are held
      if (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid)
      begin
         st_next.aw_hold = 1'b0;
         st_next.w_hold  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = RESP_OKAY;
         case (uts_decode(st_reg.awaddr))
            SEL_TOKEN:
               if (st_reg.wbyte)
               begin
                  st_next.tok_kind = st_reg.wdata[TOK_KIND_LSB +: 4];
                  st_next.tok_ep   = st_reg.wdata[3:0];
                  // reserved kinds are stored but never launched
                  st_next.tok_go   = uts_token_legal(st_reg.wdata[TOK_KIND_LSB +: 4]);
               end
            SEL_ICLEAR:
               if (st_reg.wbyte)
               begin
                  pop     = st_reg.wdata[IRQ_TRN] && (st_reg.cnt != '0);
                  clr_sof = st_reg.wdata[IRQ_SOF];
                  clr_ovf = st_reg.wdata[IRQ_OVF];
               end
            SEL_IENABLE:
               if (st_reg.wbyte)
                  st_next.irq_en = st_reg.wdata[IRQ_W-1:0];
            SEL_STATUS, SEL_FRAME, SEL_IFLAG: ; // read-only, write ignored
            default: st_next.bresp = RESP_DECERR;
         endcase
      end
      st_next.awready = !st_next.aw_hold && !st_next.bvalid;
      st_next.wready  = !st_next.w_hold && !st_next.bvalid;

      // read path answers one cycle after the address is taken
      if (s_axi_rready && st_reg.rvalid)
         st_next.rvalid = 1'b0;
      if (s_axi_arvalid && st_reg.arready)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = RESP_OKAY;
         st_next.rdata  = '0;
         case (uts_decode(s_axi_araddr[ADDR_W-1:0]))
            SEL_STATUS:
            begin
               st_next.rdata[ST_EP_LSB +: 4] = st_reg.q[0].ep;
               st_next.rdata[ST_DIR]         = st_reg.q[0].dir;
               st_next.rdata[ST_ODD]         = st_reg.q[0].odd;
            end
            SEL_FRAME:
               st_next.rdata[FRMH_W-1:0] = st_reg.frame_hi;
            SEL_TOKEN:
               st_next.rdata[7:0] = {st_reg.tok_kind, st_reg.tok_ep};
            SEL_IFLAG:
            begin
               st_next.rdata[IRQ_TRN] = (st_reg.cnt != '0);
               st_next.rdata[IRQ_SOF] = st_reg.sof_flag;
               st_next.rdata[IRQ_OVF] = st_reg.ovf_flag;
            end
            SEL_IENABLE:
               st_next.rdata[IRQ_W-1:0] = st_reg.irq_en;
            SEL_ICLEAR: ; // write-only, reads zero
            default: st_next.rresp = RESP_DECERR;
         endcase
      end
      st_next.arready = !st_next.rvalid;

      // status fifo: pop shifts toward slot 0, push lands behind the tail
      if (pop)
      begin
         for (int i = 0; i < DEPTH - 1; i++)
            st_next.q[i] = st_reg.q[i+1];
      end
      idx = st_reg.cnt - CW'(pop);
      if (push && (idx < CW'(DEPTH)))
      begin
         st_next.q[idx] = xact_info;
         st_next.cnt    = idx + CW'(1);
      end
      else
         st_next.cnt = idx;

      // sticky events: a new event beats a clear in the same cycle
      st_next.sof_flag = (st_reg.sof_flag && !clr_sof) || sof_in.seen;
      st_next.ovf_flag = (st_reg.ovf_flag && !clr_ovf) || (push && idx >= CW'(DEPTH));

      // frame bits follow every start-of-frame token
      if (sof_in.seen)
         st_next.frame_hi = sof_in.frame[FRMH_LSB +: FRMH_W];

      // done flag is a level, high while the fifo holds an entry
      flags[IRQ_TRN] = (st_next.cnt != '0);
      flags[IRQ_SOF] = st_next.sof_flag;
      flags[IRQ_OVF] = st_next.ovf_flag;
      st_next.irq    = |(flags & st_next.irq_en);
   end

   // single state register
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // outputs straight from the state register
   assign s_axi_awready  = st_reg.awready;
   assign s_axi_wready   = st_reg.wready;
   assign s_axi_bvalid   = st_reg.bvalid;
   assign s_axi_bresp    = st_reg.bresp;
   assign s_axi_arready  = st_reg.arready;
   assign s_axi_rvalid   = st_reg.rvalid;
   assign s_axi_rresp    = st_reg.rresp;
   assign s_axi_rdata    = st_reg.rdata;
   assign token_kind     = st_reg.tok_kind;
   assign token_endpoint = st_reg.tok_ep;
   assign token_go       = st_reg.tok_go;
   assign irq            = st_reg.irq;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   logic rd_status;
   logic rd_frame;
   assign rd_status = s_axi_arvalid && s_axi_arready && (s_axi_araddr[ADDR_W-1:0] == OFS_STATUS);
   assign rd_frame  = s_axi_arvalid && s_axi_arready && (s_axi_araddr[ADDR_W-1:0] == OFS_FRAME);

   property p_ep_head;
      (xact_done && st_reg.cnt == '0) |=> (st_reg.q[0].ep == $past(xact_info.ep));
   endproperty
   a_ep_head: assert property (p_ep_head) else $error("head endpoint wrong");

   property p_dir_read;
      rd_status |=> s_axi_rdata[ST_DIR] == $past(st_reg.q[0].dir);
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction bit wrong");

   property p_odd_head;
      (xact_done && st_reg.cnt == '0) |=> (st_reg.q[0].odd == $past(xact_info.odd));
   endproperty
   a_odd_head: assert property (p_odd_head) else $error("bank bit wrong");

   // no write executes this cycle, so nothing can pop: the push must be dropped
   property p_depth;
      (xact_done && st_reg.cnt == CW'(DEPTH) && !(st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid))
         |=> (st_reg.cnt == CW'(DEPTH)) && st_reg.ovf_flag;
   endproperty
   a_depth: assert property (p_depth) else $error("fifo depth exceeded");

   // a clear write executing with bit 0 set and at least two entries queued
   property p_pop;
      (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid && st_reg.awaddr == OFS_ICLEAR
       && st_reg.wbyte && st_reg.wdata[IRQ_TRN] && st_reg.cnt > CW'(1) && !xact_done)
         |=> (st_reg.q[0] == $past(st_reg.q[1])) && (st_reg.cnt == $past(st_reg.cnt) - CW'(1));
   endproperty
   a_pop: assert property (p_pop) else $error("pop did not advance head");

   property p_frame_read;
      rd_frame |=> (s_axi_rdata[31:FRMH_W] == '0) && s_axi_rvalid;
   endproperty
   a_frame_read: assert property (p_frame_read) else $error("frame read wrong");

   property p_sof_load;
      sof_in.seen |=> st_reg.frame_hi == $past(sof_in.frame[FRMH_LSB +: FRMH_W]);
   endproperty
   a_sof_load: assert property (p_sof_load) else $error("frame bits not loaded");

   property p_token_legal;
      token_go |-> (token_kind == TOK_SETUP || token_kind == TOK_IN || token_kind == TOK_OUT);
   endproperty
   a_token_legal: assert property (p_token_legal) else $error("reserved token launched");

   property p_done_irq;
      (xact_done && st_next.irq_en[IRQ_TRN]) |=> irq && (st_reg.cnt != '0);
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("done flag missing");
endmodule : uts_core
`default_nettype wire

// *** test/uts_usb_model.sv ***
/*
 * uts_usb_model: usb engine stand-in that turns bench requests into
 * one-cycle transaction and start-of-frame strobes.
 * assumes the bench drives its requests just after clk_sys rising edges.
 */
`default_nettype none
module uts_usb_model
   import uts_pkg::*;
(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   // bench requests
   input  wire logic               go_xact,
   input  wire uts_pkg::uts_xact_t go_info,
   input  wire logic               go_sof,
   input  wire logic [10:0]        go_frame,
   // engine strobes toward the slice
   output var  logic               xact_done,
   output var  uts_pkg::uts_xact_t xact_info,
   output var  uts_pkg::uts_sof_t  sof_in
);
   timeunit 1ns;
   timeprecision 1ns;

   // payload inverts outside strobes so stale data never looks valid
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         xact_done <= 1'b0;
         xact_info <= '0;
         sof_in    <= '0;
      end
      else
      begin
         xact_done    <= go_xact;
         xact_info    <= go_xact ? go_info : ~xact_info;
         sof_in.seen  <= go_sof;
         sof_in.frame <= go_sof ? go_frame : ~sof_in.frame;
      end
   end
endmodule : uts_usb_model
`default_nettype wire

// *** test/usb_transfer_status_and_token_test.sv ***
/*
 * usb_transfer_status_and_token_test: self-checking bench for uts_core,
 * driving axi4-lite as master and usb events through uts_usb_model.
 * assumes the register map and field positions of uts_pkg.
 */
`default_nettype none
module usb_transfer_status_and_token_test;
   timeunit 1ns;
   timeprecision 100ps;
   import uts_pkg::*;

   logic              clk_sys = 1'b0;
   logic              rst_b   = 1'b0;
   logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]        s_axi_wstrb, token_kind, token_endpoint;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic              token_go, irq, xact_done, go_xact, go_sof;
   logic [10:0]       go_frame, f;
   uts_xact_t         xact_info, go_info;
   uts_xact_t         xs [5];
   uts_sof_t          sof_in;
   logic [3:0]        kinds [4] = '{TOK_SETUP, TOK_IN, TOK_OUT, 4'h7};
   logic [3:0]        ep;
   integer            seed;
   int                n_fail, n_checks, n_go, g0, cyc;

   always #12.5 clk_sys = ~clk_sys;

   uts_core #(.DEPTH(STAT_DEPTH)) DUT (
      .clk_sys(clk_sys), .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .xact_done(xact_done), .xact_info(xact_info), .sof_in(sof_in),
      .token_kind(token_kind), .token_endpoint(token_endpoint), .token_go(token_go),
      .irq(irq)
   );
   uts_usb_model usb (
      .clk_sys(clk_sys), .rst_b(rst_b), .go_xact(go_xact), .go_info(go_info),
      .go_sof(go_sof), .go_frame(go_frame), .xact_done(xact_done), .xact_info(xact_info),
      .sof_in(sof_in)
   );

   // count launches and cut a hang short
   always @(posedge clk_sys)
   begin
      if (token_go === 1'b1) n_go++;
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         summarize();
      end
   end

   task automatic summarize;
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [31:0] st_word(input uts_xact_t x);
      return (32'(x.ep) << ST_EP_LSB) | (32'(x.dir) << ST_DIR) | (32'(x.odd) << ST_ODD);
   endfunction : st_word

   // one write; address and data released each as taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr  <= 32'(a);
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      // only the bench timeout ends a wait
      while (!done)
      begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            chk(32'(s_axi_bresp), 32'(er));
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : wr

   // one read compared against the expected word and response
   task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr  <= 32'(a);
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!done)
      begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            chk(s_axi_rdata, ed);
            chk(32'(s_axi_rresp), 32'(er));
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : rd

   task automatic push(input uts_xact_t x, input logic sof, input logic [10:0] fr);
      @(posedge clk_sys);
      go_xact  <= !sof;
      go_info  <= x;
      go_sof   <= sof;
      go_frame <= fr;
      @(posedge clk_sys);
      go_xact <= 1'b0;
      go_sof  <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : push

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk_sys);
      chk(32'(irq), 32'(e));
   endtask : irq_is

   initial
   begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {go_xact, go_sof, go_info, go_frame} = '0;
      {n_fail, n_checks, n_go, cyc} = '0;
      seed = 41;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      // reset contents, unmapped and read-only places
      rd(OFS_TOKEN, 32'h0, RESP_OKAY);
      rd(OFS_FRAME, 32'h0, RESP_OKAY);
      rd(OFS_IFLAG, 32'h0, RESP_OKAY);
      wr(5'h18, 32'hffff_ffff, 4'hf, RESP_DECERR);
      rd(5'h18, 32'h0, RESP_DECERR);
      // five pushes into a four-deep queue; corners first, then random
      for (int i = 0; i < 5; i++)
      begin
         xs[i] = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($random(seed));
         push(xs[i], 1'b0, 11'h0);
      end
      rd(OFS_IFLAG, 32'h5, RESP_OKAY);
      wr(OFS_IENABLE, 32'h1, 4'hf, RESP_OKAY);
      irq_is(1'b1);
      wr(OFS_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         rd(OFS_IFLAG, (i == 0) ? 32'h5 : 32'h5, RESP_OKAY);
         rd(OFS_STATUS, st_word(xs[i]), RESP_OKAY);
         wr(OFS_ICLEAR, 32'h1, 4'hf, RESP_OKAY);
      end
      rd(OFS_IFLAG, 32'h4, RESP_OKAY);
      irq_is(1'b0);
      // a push into the empty queue with the done interrupt enabled
      push(xs[4], 1'b0, 11'h0);
      irq_is(1'b1);
      rd(OFS_STATUS, st_word(xs[4]), RESP_OKAY);
      wr(OFS_ICLEAR, 32'h1, 4'hf, RESP_OKAY);
      irq_is(1'b0);
      wr(OFS_ICLEAR, 32'h4, 4'hf, RESP_OKAY);
      rd(OFS_IFLAG, 32'h0, RESP_OKAY);
      // start-of-frame numbers at both ends of the range and one random
      for (int i = 0; i < 3; i++)
      begin
         f = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'($random(seed));
         push('0, 1'b1, f);
         wr(OFS_FRAME, 32'hffff_ffff, 4'hf, RESP_OKAY);
         rd(OFS_FRAME, 32'(f[FRAME_W-1:FRMH_LSB]), RESP_OKAY);
      end
      rd(OFS_IFLAG, 32'h2, RESP_OKAY);
      wr(OFS_IENABLE, 32'h2, 4'hf, RESP_OKAY);
      irq_is(1'b1);
      wr(OFS_ICLEAR, 32'h2, 4'hf, RESP_OKAY);
      irq_is(1'b0);
      // every token kind plus one reserved code, junk in the upper bits
      for (int k = 0; k < 4; k++)
      begin
         ep = 4'($random(seed));
         g0 = n_go;
         wr(OFS_TOKEN, {24'($random(seed)), kinds[k], ep}, 4'hf, RESP_OKAY);
         rd(OFS_TOKEN, (32'(kinds[k]) << TOK_KIND_LSB) | 32'(ep), RESP_OKAY);
         chk(32'({token_kind, token_endpoint}), 32'({kinds[k], ep}));
         chk(32'(n_go - g0), (k < 3) ? 32'h1 : 32'h0);
      end
      // a write with its byte strobe off leaves the token alone
      wr(OFS_TOKEN, 32'h15, 4'h0, RESP_OKAY);
      rd(OFS_TOKEN, (32'(kinds[3]) << TOK_KIND_LSB) | 32'(ep), RESP_OKAY);
      summarize();
   end
endmodule : usb_transfer_status_and_token_test
`default_nettype wire
